// >>> hdl/spi_defs.svh
// constants for the serial port engine and its receive buffer
// assumes inclusion by bare name from the main module
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH
`define BYTE_W 8
`define CAPTURES_PER_BYTE 4'd8
`define LAST_CAPTURE 4'd7
`define TOGGLES_PER_BYTE 5'd16
`define HALF_BASE 10'd2
`define PIN_SYNC_RESET 4'h1
`define RX_FIFO_DEPTH 16
`endif

// >>> hdl/spi_pkg.sv
// types shared by the serial port engine
// assumes spi_defs.svh is on the include path
package spi_pkg;
   typedef enum logic [1:0]
   {
      st_idle = 2'b01,
      st_run = 2'b10
   } xfer_state_type;
endpackage

// >>> hdl/spi_rx_fifo.sv
// receive buffer: valid/ready fifo with width and depth parameters
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module spi_rx_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      begin : g_bad
         $error("fifo depth must be a power of two, two or more");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   // extra pointer bit tells full from empty
   assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// >>> hdl/spi_master_slave_engine.sv
// byte-wide full-duplex serial port, master or slave
// assumes cpu strobes on clk_i; link pins asynchronous, synchronised here
`timescale 1ns/1ps
`include "spi_defs.svh"
module spi_master_slave_engine
   import spi_pkg::*;
#(
   parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // control register write
   input wire logic ctrl_write_i,
   input wire logic port_irq_enable_i,
   input wire logic port_enable_i,
   input wire logic master_select_i,
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic [2:0] baud_rate_field_i,
   // control/status register access
   input wire logic csr_read_i,
   input wire logic csr_write_i,
   input wire logic select_soft_manage_i,
   input wire logic select_soft_level_i,
   // data register access
   input wire logic dr_write_i,
   input wire logic [`BYTE_W-1:0] dr_wdata_i,
   input wire logic dr_read_i,
   output logic [`BYTE_W-1:0] dr_rdata_o,
   output logic rx_valid_o,
   // cpu interrupt mask
   input wire logic cpu_int_mask_i,
   // state
   output logic port_enable_o,
   output logic master_select_o,
   output logic transfer_done_flag_o,
   output logic mode_fault_flag_o,
   output logic overrun_flag_o,
   output logic write_collision_flag_o,
   output logic irq_o,
   // link pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   input wire logic ss_n_i
);
   generate
      if (FIFO_DEPTH < 2)
      begin : g_bad
         $error("receive buffer needs two or more entries");
      end
   endgenerate

   // control and status
   logic irq_en;
   logic port_en;
   logic master;
   logic cpol;
   logic cpha;
   logic [2:0] baud;
   logic soft_manage;
   logic soft_level;
   logic done_flag;
   logic csr_seen;
   logic mode_fault_flag;
   logic mode_fault_flag_read_seen;
   logic overrun_flag;
   logic write_collision_flag;
   logic write_collision_flag_seen;
   // pins: {sck, mosi, miso, ss_n}
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   // transfer engine
   xfer_state_type state;
   logic [`BYTE_W-1:0] sh;
   logic cap;
   logic [3:0] cap_cnt;
   logic [9:0] half_cnt;
   logic [9:0] half_len;
   logic [4:0] tog_cnt;
   logic sck_gen;
   logic sck_prev;
   logic sck_now;
   logic lead;
   logic trail;
   logic cap_edge;
   logic shift_edge;
   logic din;
   logic ss_int_n;
   logic xfer_en;
   logic busy;
   logic dr_block;
   logic wr_ok;
   logic write_collision_flag_event;
   logic start_master;
   logic fault_event;
   logic xfer_done;
   logic done_clear;
   logic ovr_event;
   logic fifo_in_ready;
   logic ctrl_allow;

   // two flops before any logic reads a pin
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         pin_meta <= `PIN_SYNC_RESET;
         pin_sync <= `PIN_SYNC_RESET;
      end
      else
      begin
         pin_meta <= {sck_i, mosi_i, miso_i, ss_n_i};
         pin_sync <= pin_meta;
      end
   end

   assign ss_int_n = soft_manage ? soft_level : pin_sync[0];
   assign fault_event = port_en && master && !ss_int_n;
   assign ctrl_allow = !mode_fault_flag || mode_fault_flag_read_seen;

   // control register; fault overrides a same-cycle write of enable and master
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_en <= 1'b0;
         port_en <= 1'b0;
         master <= 1'b0;
         cpol <= 1'b0;
         cpha <= 1'b0;
         baud <= '0;
      end
      else
      begin
         if (ctrl_write_i)
         begin
            irq_en <= port_irq_enable_i;
            cpol <= cpol_i;
            cpha <= cpha_i;
            baud <= baud_rate_field_i;
            port_en <= port_enable_i && ctrl_allow;
            master <= master_select_i && ctrl_allow;
         end
         if (fault_event)
         begin
            port_en <= 1'b0;
            master <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         soft_manage <= 1'b0;
         soft_level <= 1'b0;
      end
      else if (csr_write_i)
      begin
         soft_manage <= select_soft_manage_i;
         soft_level <= select_soft_level_i;
      end
   end

   // mode fault flag and its clearing sequence; set wins
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         mode_fault_flag <= 1'b0;
         mode_fault_flag_read_seen <= 1'b0;
      end
      else
      begin
         if (fault_event)
         begin
            mode_fault_flag <= 1'b1;
         end
         else if (ctrl_write_i && mode_fault_flag_read_seen)
         begin
            mode_fault_flag <= 1'b0;
         end
         if (!mode_fault_flag || ctrl_write_i)
         begin
            mode_fault_flag_read_seen <= 1'b0;
         end
         else if (csr_read_i)
         begin
            mode_fault_flag_read_seen <= 1'b1;
         end
      end
   end

   // edge finder works on generated or sampled clock alike
   assign sck_now = master ? sck_gen : pin_sync[3];
   assign lead = (sck_prev == cpol) && (sck_now != cpol);
   assign trail = (sck_prev != cpol) && (sck_now == cpol);
   assign cap_edge = cpha ? trail : lead;
   assign shift_edge = cpha ? lead : trail;
   assign din = master ? pin_sync[1] : pin_sync[2];
   assign xfer_en = port_en && (master ? (state == st_run) : !ss_int_n);
   // phase zero slave is busy for as long as it is selected
   assign busy = (state == st_run) ||
                 (port_en && !master && !cpha && !ss_int_n);
   assign dr_block = done_flag && !csr_seen;
   assign wr_ok = dr_write_i && !dr_block && !busy;
   assign write_collision_flag_event = dr_write_i && !dr_block && busy;
   assign start_master = wr_ok && master && port_en;
   assign half_len = `HALF_BASE << baud;
   assign xfer_done = xfer_en && ((cpha && cap_edge &&
                      cap_cnt == `LAST_CAPTURE) ||
                      (!cpha && shift_edge &&
                      cap_cnt == `CAPTURES_PER_BYTE));
   assign ovr_event = xfer_done && (done_flag || !fifo_in_ready);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         sck_prev <= 1'b0;
      end
      else
      begin
         sck_prev <= sck_now;
      end
   end

   // transfer sequencing
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state <= st_idle;
         cap_cnt <= '0;
      end
      else
      begin
         case (state)
            st_idle:
            begin
               if (start_master)
               begin
                  state <= st_run;
               end
               else if (xfer_en && (lead || trail))
               begin
                  state <= st_run;
               end
            end
            st_run:
            begin
               if (!port_en || (!master && ss_int_n) || xfer_done)
               begin
                  state <= st_idle;
               end
            end
            default:
            begin
               state <= st_idle;
            end
         endcase
         if (!xfer_en || xfer_done)
         begin
            cap_cnt <= '0;
         end
         else if (cap_edge)
         begin
            cap_cnt <= cap_cnt + 1'b1;
         end
      end
   end

   // shift register: load on accepted write, shift per edge
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         sh <= '0;
         cap <= 1'b0;
      end
      else
      begin
         if (state == st_idle && wr_ok)
         begin
            sh <= dr_wdata_i;
         end
         else if (xfer_en)
         begin
            if (cap_edge)
            begin
               cap <= din;
            end
            if (cpha && cap_edge && cap_cnt == `LAST_CAPTURE)
            begin
               sh <= {sh[`BYTE_W-2:0], din};
            end
            else if (shift_edge && cap_cnt != '0)
            begin
               sh <= {sh[`BYTE_W-2:0], cap};
            end
         end
      end
   end

   // master clock generator; idles at the chosen polarity
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         sck_gen <= 1'b0;
         half_cnt <= '0;
         tog_cnt <= '0;
      end
      else if (state != st_run || !master)
      begin
         sck_gen <= cpol;
         half_cnt <= '0;
         tog_cnt <= '0;
      end
      else if (half_cnt == half_len - 10'd1)
      begin
         half_cnt <= '0;
         if (tog_cnt != `TOGGLES_PER_BYTE)
         begin
            sck_gen <= !sck_gen;
            tog_cnt <= tog_cnt + 5'd1;
         end
      end
      else
      begin
         half_cnt <= half_cnt + 10'd1;
      end
   end

   // completion flag, clear sequence; set wins over clear
   assign done_clear = csr_seen &&
                       (dr_read_i || (!master && dr_write_i));
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         done_flag <= 1'b0;
         csr_seen <= 1'b0;
      end
      else
      begin
         if (xfer_done)
         begin
            done_flag <= 1'b1;
         end
         else if (done_clear)
         begin
            done_flag <= 1'b0;
         end
         if (!done_flag || done_clear)
         begin
            csr_seen <= 1'b0;
         end
         else if (csr_read_i || csr_write_i)
         begin
            csr_seen <= 1'b1;
         end
      end
   end

   // overrun clears on status read alone; collision by read then data
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         overrun_flag <= 1'b0;
         write_collision_flag <= 1'b0;
         write_collision_flag_seen <= 1'b0;
      end
      else
      begin
         if (ovr_event)
         begin
            overrun_flag <= 1'b1;
         end
         else if (csr_read_i)
         begin
            overrun_flag <= 1'b0;
         end
         if (write_collision_flag_event)
         begin
            write_collision_flag <= 1'b1;
         end
         else if (write_collision_flag_seen && (dr_read_i || dr_write_i))
         begin
            write_collision_flag <= 1'b0;
         end
         if (!write_collision_flag)
         begin
            write_collision_flag_seen <= 1'b0;
         end
         else if (csr_read_i)
         begin
            write_collision_flag_seen <= 1'b1;
         end
      end
   end

   // only the first byte after a clear enters the buffer
   spi_rx_fifo
   #(
      .WIDTH(`BYTE_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_rx_fifo
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(xfer_done && !done_flag),
      .in_ready_o(fifo_in_ready),
      // last bit joins here; phase zero holds it in cap until the trail
      .in_data_i({sh[`BYTE_W-2:0], cpha ? din : cap}),
      .out_valid_o(rx_valid_o),
      .out_ready_i(dr_read_i),
      .out_data_o(dr_rdata_o)
   );

   // collision flag is status only, never an interrupt source
   assign irq_o = irq_en && !cpu_int_mask_i &&
                  (done_flag || mode_fault_flag || overrun_flag);

   // pins; enables low while driving, all released when disabled
   assign sck_o = sck_gen;
   assign mosi_o = sh[`BYTE_W-1];
   assign miso_o = sh[`BYTE_W-1];
   assign sck_oe_n_o = !(port_en && master);
   assign mosi_oe_n_o = !(port_en && master);
   assign miso_oe_n_o = !(port_en && !master && !ss_int_n);
   assign port_enable_o = port_en;
   assign master_select_o = master;
   assign transfer_done_flag_o = done_flag;
   assign mode_fault_flag_o = mode_fault_flag;
   assign overrun_flag_o = overrun_flag;
   assign write_collision_flag_o = write_collision_flag;

   a_fault_drops_master: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      fault_event |=> !port_en && !master && mode_fault_flag && sck_oe_n_o)
      else $error("mode fault did not drop enable and master");
   a_fault_refuses_set: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      mode_fault_flag && !mode_fault_flag_read_seen && ctrl_write_i |=> !port_en && !master)
      else $error("enable set while fault flag pending");
   a_fault_clear_seq: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      mode_fault_flag && mode_fault_flag_read_seen && ctrl_write_i && !fault_event |=> !mode_fault_flag)
      else $error("fault flag not cleared by control write");
   a_done_sets_flag: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      xfer_done |=> done_flag && state == st_idle)
      else $error("completion did not set done flag");
   a_overrun_keeps: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      xfer_done && done_flag |=> overrun_flag && $stable(rx_valid_o))
      else $error("overrun not flagged or byte pushed");
   a_ovr_read_clear: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      csr_read_i && !ovr_event |=> !overrun_flag)
      else $error("overrun flag survived status read");
   a_blocked_write: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      dr_block && dr_write_i && state == st_idle |=>
      $stable(sh) && !$rose(write_collision_flag))
      else $error("data write taken while done flag pending");
   a_write_collision_flag_no_irq: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      write_collision_flag && !done_flag && !mode_fault_flag && !overrun_flag |-> !irq_o)
      else $error("collision flag raised interrupt");
   a_irq_gating: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      irq_en && !cpu_int_mask_i && (done_flag || mode_fault_flag || overrun_flag) |-> irq_o)
      else $error("enabled event without interrupt");
   a_rx_buffered: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      xfer_done && !done_flag && fifo_in_ready |=> rx_valid_o)
      else $error("received byte not buffered");
endmodule

// >>> verification/spi_far_end.sv
// far-end model: a serial slave answering the engine, or a master driving it
// assumes the bench resolves the wire levels and feeds them back here
`timescale 1ns/1ps
module spi_far_end
(
   // timing mode, same as the engine's
   input wire logic cpol_i,
   input wire logic cpha_i,
   // resolved wire levels
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   // far-end drivers
   output logic sck_o,
   output logic mosi_o,
   output logic miso_o,
   output logic ss_n_o
);
   logic slave_on = 1'b0;
   logic m_on = 1'b0;
   logic m_sck = 1'b0;
   logic [7:0] out_sr = 8'h00;
   logic [7:0] in_sr = 8'h00;

   // idle clock follows polarity, as a pull would
   assign sck_o = m_on ? m_sck : cpol_i;

   initial
   begin
      mosi_o = 1'b0;
      miso_o = 1'b0;
      ss_n_o = 1'b1;
   end

   // slave role: capture edge chosen by polarity and phase
   always @(sck_i)
   begin
      if (slave_on)
      begin
         if ((sck_i !== cpol_i) ^ cpha_i)
            in_sr = {in_sr[6:0], mosi_i};
         else
            shift_out();
      end
   end

   task automatic shift_out();
      miso_o = out_sr[7];
      out_sr = {out_sr[6:0], ~out_sr[7]};
   endtask

   task automatic slave_begin(input logic [7:0] tx);
      out_sr = tx;
      in_sr = 8'h00;
      slave_on = 1'b1;
      if (!cpha_i)
         shift_out();
   endtask

   task automatic slave_end(output logic [7:0] rx);
      rx = in_sr;
      slave_on = 1'b0;
      // released line shows no stale bit
      miso_o = ~miso_o;
   endtask

   task automatic set_select(input logic v);
      ss_n_o = v;
   endtask

   // master role: 80 ns link clock, only within the frame
   task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
      ss_n_o = 1'b0;
      m_on = 1'b1;
      if (!cpha_i)
         mosi_o = tx[7];
      #40;
      for (int i = 7; i >= 0; i--)
      begin
         m_sck = ~cpol_i;
         if (cpha_i)
            mosi_o = tx[i];
         else
            rx[i] = miso_i;
         #40;
         m_sck = cpol_i;
         if (cpha_i)
            rx[i] = miso_i;
         else if (i > 0)
            mosi_o = tx[i-1];
         #40;
      end
      ss_n_o = 1'b1;
      m_on = 1'b0;
      mosi_o = ~mosi_o;
   endtask
endmodule

// >>> verification/tb.sv
// bench for the serial port engine and its receive buffer
// assumes the far-end model file is compiled first
`timescale 1ns/1ps
module tb;
   logic clk_i, reset_n_i, ctrl_write_i, port_irq_enable_i, port_enable_i;
   logic master_select_i, cpol_i, cpha_i, csr_read_i, csr_write_i;
   logic select_soft_manage_i, select_soft_level_i, dr_write_i, dr_read_i;
   logic cpu_int_mask_i, rx_valid_o, port_enable_o, master_select_o;
   logic [2:0] baud_rate_field_i;
   logic [7:0] dr_wdata_i, dr_rdata_o;
   logic transfer_done_flag_o, mode_fault_flag_o, overrun_flag_o, irq_o;
   logic write_collision_flag_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o;
   logic miso_o, miso_oe_n_o, sck_w, mosi_w, miso_w;
   logic p_sck, p_mosi, p_miso, p_ss_n;
   int fails = 0;
   int samples_checked = 0;

   // wire levels from all drivers, enables active low
   assign sck_w = sck_oe_n_o ? p_sck : sck_o;
   assign mosi_w = mosi_oe_n_o ? p_mosi : mosi_o;
   assign miso_w = miso_oe_n_o ? p_miso : miso_o;

   spi_master_slave_engine spi_master_slave_engine_i
   (
      .clk_i, .reset_n_i, .ctrl_write_i, .port_irq_enable_i, .port_enable_i,
      .master_select_i, .cpol_i, .cpha_i, .baud_rate_field_i, .csr_read_i,
      .csr_write_i, .select_soft_manage_i, .select_soft_level_i,
      .dr_write_i, .dr_wdata_i, .dr_read_i, .dr_rdata_o, .rx_valid_o,
      .cpu_int_mask_i, .port_enable_o, .master_select_o,
      .transfer_done_flag_o, .mode_fault_flag_o, .overrun_flag_o,
      .write_collision_flag_o, .irq_o, .sck_i(sck_w), .sck_o, .sck_oe_n_o,
      .mosi_i(mosi_w), .mosi_o, .mosi_oe_n_o, .miso_i(miso_w), .miso_o,
      .miso_oe_n_o, .ss_n_i(p_ss_n)
   );

   spi_far_end spi_far_end_i
   (
      .cpol_i, .cpha_i, .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
      .sck_o(p_sck), .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ss_n)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic flag(input logic got, input logic exp);
      check({7'h00, got}, {7'h00, exp});
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // strobe held one edge, then a quiet edge so no double assignment
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
   endtask

   task automatic put(input logic [7:0] d);
      dr_wdata_i = d;
      pulse(dr_write_i);
   endtask

   task automatic ctrl(input logic ie, en, ms, pol, pha, input logic [2:0] br);
      {port_irq_enable_i, port_enable_i, master_select_i} = {ie, en, ms};
      {cpol_i, cpha_i, baud_rate_field_i} = {pol, pha, br};
      pulse(ctrl_write_i);
   endtask

   task automatic csr(input logic select_soft_manage, select_soft_level);
      {select_soft_manage_i, select_soft_level_i} = {select_soft_manage, select_soft_level};
      pulse(csr_write_i);
   endtask

   // sel 0 waits for done, 1 for fault
   task automatic wait_for(input logic sel);
      int n;
      for (n = 0; n < 3000; n++)
      begin
         if ((sel ? mode_fault_flag_o : transfer_done_flag_o) === 1'b1)
            break;
         tick();
      end
      if (n == 3000)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, 0, 1);
         print_verdict();
      end
   endtask

   task automatic master_mode(input logic pol, pha, input logic [2:0] br);
      logic [7:0] got;
      logic [7:0] tx;
      tx = 8'hc5 + {5'h00, br};
      cpol_i = pol;
      cpha_i = pha;
      csr(1'b1, 1'b1);
      ctrl(1'b1, 1'b1, 1'b1, pol, pha, br);
      flag(sck_o, pol);
      spi_far_end_i.slave_begin(8'h3a + {5'h00, br});
      put(tx);
      put(8'h11);
      flag(write_collision_flag_o, 1'b1);
      flag(irq_o, 1'b0);
      wait_for(1'b0);
      check(dr_rdata_o, 8'h3a + {5'h00, br});
      flag(irq_o, 1'b1);
      cpu_int_mask_i = 1'b1;
      tick();
      flag(irq_o, 1'b0);
      cpu_int_mask_i = 1'b0;
      // ignored write would shift more bits into the far end
      put(8'h22);
      tick(300);
      spi_far_end_i.slave_end(got);
      check(got, tx);
      pulse(csr_read_i);
      pulse(dr_read_i);
      flag(transfer_done_flag_o, 1'b0);
      flag(rx_valid_o, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, pol, pha, br);
   endtask

   task automatic fault_case();
      csr(1'b0, 1'b1);
      ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
      spi_far_end_i.set_select(1'b0);
      wait_for(1'b1);
      tick();
      flag(port_enable_o, 1'b0);
      flag(master_select_o, 1'b0);
      flag(mosi_oe_n_o, 1'b1);
      flag(sck_oe_n_o, 1'b1);
      flag(irq_o, 1'b1);
      spi_far_end_i.set_select(1'b1);
      ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
      flag(port_enable_o, 1'b0);
      flag(mode_fault_flag_o, 1'b1);
      pulse(csr_read_i);
      ctrl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0);
      flag(mode_fault_flag_o, 1'b0);
      flag(master_select_o, 1'b1);
      csr(1'b1, 1'b0);
      wait_for(1'b1);
      flag(irq_o, 1'b0);
      csr(1'b1, 1'b1);
      pulse(csr_read_i);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
      flag(mode_fault_flag_o, 1'b0);
   endtask

   task automatic slave_mode(input logic pol, pha);
      logic [7:0] got;
      cpol_i = pol;
      cpha_i = pha;
      csr(1'b0, 1'b1);
      ctrl(1'b1, 1'b1, 1'b0, pol, pha, 3'h0);
      put(8'h5c ^ {6'h00, pol, pha});
      if (!pha)
      begin
         spi_far_end_i.set_select(1'b0);
         tick(4);
         put(8'h77);
         flag(write_collision_flag_o, 1'b1);
         flag(miso_oe_n_o, 1'b0);
         spi_far_end_i.set_select(1'b1);
         tick(4);
      end
      spi_far_end_i.master_xfer(8'ha3 ^ {6'h00, pol, pha}, got);
      check(got, 8'h5c ^ {6'h00, pol, pha});
      wait_for(1'b0);
      check(dr_rdata_o, 8'ha3 ^ {6'h00, pol, pha});
      pulse(csr_read_i);
      pulse(dr_read_i);
      flag(transfer_done_flag_o, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, pol, pha, 3'h0);
   endtask

   task automatic overrun_case();
      logic [7:0] got;
      cpol_i = 1'b0;
      cpha_i = 1'b1;
      ctrl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
      put(8'h01);
      spi_far_end_i.master_xfer(8'hb1, got);
      wait_for(1'b0);
      spi_far_end_i.master_xfer(8'hb2, got);
      tick(4);
      flag(overrun_flag_o, 1'b1);
      flag(irq_o, 1'b1);
      pulse(csr_read_i);
      flag(overrun_flag_o, 1'b0);
      put(8'h02);
      flag(transfer_done_flag_o, 1'b0);
      check(dr_rdata_o, 8'hb1);
      pulse(dr_read_i);
      flag(rx_valid_o, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
   endtask

   // slave clears by data write, so bytes pile up; the 17th finds it full
   task automatic fifo_case();
      logic [7:0] got;
      ctrl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
      for (int k = 0; k < 17; k++)
      begin
         spi_far_end_i.master_xfer(k[7:0], got);
         wait_for(1'b0);
         flag(overrun_flag_o, k == 16);
         pulse(csr_read_i);
         put(8'h00);
      end
      for (int k = 0; k < 16; k++)
      begin
         check(dr_rdata_o, k[7:0]);
         pulse(dr_read_i);
      end
      flag(rx_valid_o, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
   endtask

   initial
   begin
      {reset_n_i, ctrl_write_i, port_irq_enable_i, port_enable_i} = '0;
      {master_select_i, cpol_i, cpha_i, baud_rate_field_i} = '0;
      {csr_read_i, csr_write_i, select_soft_manage_i} = '0;
      {select_soft_level_i, dr_write_i, dr_wdata_i, dr_read_i} = '0;
      cpu_int_mask_i = 1'b0;
      tick(3);
      reset_n_i = 1'b1;
      tick();
      for (int m = 0; m < 4; m++)
         master_mode(m[1], m[0], m[2:0]);
      fault_case();
      for (int m = 0; m < 4; m++)
         slave_mode(m[1], m[0]);
      overrun_case();
      fifo_case();
      print_verdict();
   end
endmodule
